/* File: include/safd_regs.svh */
// Constants for the serial API frame dispatcher: bytes, frame types, offsets, timing
`ifndef SAFD_REGS_SVH
`define SAFD_REGS_SVH
`define SAFD_DEPTH       32
`define SAFD_IW          6
`define SAFD_DELIM       8'h7e
`define SAFD_ESC         8'h7d
`define SAFD_ESC_XOR     8'h20
`define SAFD_XON         8'h11
`define SAFD_XOFF        8'h13
`define SAFD_CK_GOOD     8'hff
`define SAFD_OK          8'h00
`define SAFD_T_CMD       8'h08
`define SAFD_T_QCMD      8'h09
`define SAFD_T_RESP      8'h88
`define SAFD_T_RREQ      8'h17
`define SAFD_T_RRESP     8'h97
`define SAFD_T_TXREQ     8'h10
`define SAFD_T_EXPL      8'h11
`define SAFD_T_TXST      8'h8b
`define SAFD_T_RXPKT     8'h90
`define SAFD_T_RXEXP     8'h91
`define SAFD_T_IO        8'h92
`define SAFD_T_SENS      8'h94
`define SAFD_T_NODE      8'h95
`define SAFD_C_APPLY     16'h4143
`define SAFD_C_PERSIST   16'h5752
`define SAFD_C_BIND      16'h5742
`define SAFD_C_RESTORE   16'h5245
`define SAFD_C_SOFT      16'h4652
`define SAFD_C_NET       16'h4e52
`define SAFD_C_DISC      16'h4e44
`define SAFD_P_PAN       3'h0
`define SAFD_P_MASK      3'h1
`define SAFD_PARAM_RST   8'h00
`define SAFD_REG_CTRL    4'h0
`define SAFD_REG_STAT    4'h4
`define SAFD_CTRL_RST    3'h0
`define SAFD_CTRL_FMT    0
`define SAFD_CTRL_STUFF  1
`define SAFD_CTRL_COORD  2
`define SAFD_RESTART_MS  2000
`define SAFD_CLK_KHZ     125000
`endif

/* File: include/safd_pkg.sv */
// Types of the serial API frame dispatcher
`include "safd_regs.svh"
package safd_pkg;
  typedef enum logic [8:0] {
    S_HUNT = 9'h001,
    S_LH   = 9'h002,
    S_LL   = 9'h004,
    S_DAT  = 9'h008,
    S_CK   = 9'h010,
    S_EXEC = 9'h020,
    S_FWD  = 9'h040,
    S_EVT  = 9'h080,
    S_TX   = 9'h100
  } safd_st_t;
  typedef enum logic [2:0] {
    EV_TX_STATUS = 3'h0,
    EV_RX_PKT    = 3'h1,
    EV_IO        = 3'h2,
    EV_SENSOR    = 3'h3,
    EV_NODE_ID   = 3'h4,
    EV_REMOTE    = 3'h5,
    EV_CMD_RESP  = 3'h6
  } safd_ev_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } safd_byte_t;
  typedef struct packed {
    logic       valid;
    safd_ev_t   kind;
    logic [7:0] data;
    logic       last;
  } safd_evt_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } safd_rad_t;
  typedef struct packed {
    logic nvm_write;
    logic bind_write;
    logic sys_reset;
    logic net_restart;
    logic net_bcast;
  } safd_ctl_t;
  typedef struct packed {
    safd_st_t                         st;
    logic                             esc;
    logic [15:0]                      rlen;
    logic [15:0]                      rcnt;
    logic [7:0]                       rsum;
    logic [`SAFD_DEPTH-1:0][7:0]      rbuf;
    logic [`SAFD_DEPTH-1:0][7:0]      obuf;
    logic [`SAFD_IW-1:0]              olen;
    logic                             drop;
    logic                             hold;
    logic [`SAFD_IW-1:0]              tidx;
    logic [7:0]                       tsum;
    logic                             tesc;
    logic [7:0]                       tpend;
    logic                             tlast;
    logic [`SAFD_IW-1:0]              fidx;
    logic [7:0][7:0]                  params;
    logic [7:0][7:0]                  pend;
    logic [7:0]                       pend_v;
    logic                             chg;
    logic                             rarm;
    logic [27:0]                      rsd;
    logic [2:0]                       ctrl;
    logic                             rx_rdy;
    logic                             ev_rdy;
    safd_byte_t                       tx;
    safd_rad_t                        rt;
    safd_ctl_t                        ctl;
    logic [31:0]                      rdata;
  } safd_state_t;
endpackage

/* File: rtl/safd_dispatcher.sv */
// Serial API frame dispatcher: host frame parser, command executor, radio bridge, frame sender
// Functional notes
// - Queued parameter writes wait for apply
// - Queued frame without value reads at once
// - Every local command except node discovery gets a response frame
// - One command may yield several responses
// - Remote command request forwarded to radio
// - Remote replies become remote response frames
// - Transmit request payload sent over radio
// - Explicit frame sent with endpoint and cluster
// - Transmit completion gives a status frame
// - Format zero: plain receive packet frames
// - Format one: explicit receive indicator frames
// - Remote IO samples become sample frames
// - Format zero: sensor samples become frames
// - Coordinator, format zero: node announce frames
// - Persist command stores parameters non-volatile
// - Persist bindings copies binding table
// - Restore defaults but keep PAN number
// - Soft restart: OK, then reset later
// - Soft restart restarts network if changed
// - Network restart: OK, local or broadcast
// - Checksum is 0xff minus byte sum
// - Stuffing escapes special bytes with 0x7d
// - Bytes before delimiter dropped, resync on it
`timescale 1ns/1ps
`default_nettype none
`include "safd_regs.svh"
module safd_dispatcher #(
  parameter int RESTART_CYC = `SAFD_RESTART_MS * `SAFD_CLK_KHZ
) (
  // Clock, reset, enable
  input  wire  logic                ref_clk_in,
  input  wire  logic                sys_rst_in,
  input  wire  logic                ce_in,
  // Host UART byte stream
  input  wire  safd_pkg::safd_byte_t host_rx_in,
  output logic                      host_rx_ready_out,
  output var   safd_pkg::safd_byte_t host_tx_out,
  input  wire  logic                host_tx_ready_in,
  // Radio side
  input  wire  safd_pkg::safd_evt_t rad_evt_in,
  output logic                      rad_evt_ready_out,
  output var   safd_pkg::safd_rad_t rad_tx_out,
  input  wire  logic                rad_tx_ready_in,
  // System actions
  output var   safd_pkg::safd_ctl_t sys_ctl_out,
  // Register port
  input  wire  logic [3:0]          reg_addr_in,
  input  wire  logic [31:0]         reg_wdata_in,
  input  wire  logic                reg_wr_in,
  input  wire  logic                reg_rd_in,
  output logic [31:0]               reg_rdata_out
);
  import safd_pkg::*;

  safd_state_t         r;
  safd_state_t         n;
  logic                take;
  logic                etake;
  logic [7:0]          d;
  logic [7:0]          raw;
  logic [15:0]         code;
  logic                hasv;
  logic [2:0]          pidx;
  logic                islast;
  logic [`SAFD_IW-1:0] nf;
  logic                stuff;
  logic                fmt1;

  function automatic logic special(input logic [7:0] b);
    return b == `SAFD_DELIM || b == `SAFD_ESC || b == `SAFD_XON || b == `SAFD_XOFF;
  endfunction

  function automatic logic host_st(input safd_st_t s);
    return s == S_HUNT || s == S_LH || s == S_LL || s == S_DAT || s == S_CK;
  endfunction

  always_comb begin
    n      = r;
    n.ctl  = '0;
    n.rdata = 32'h0;
    take   = host_rx_in.valid & r.rx_rdy;
    etake  = rad_evt_in.valid & r.ev_rdy;
    stuff  = r.ctrl[`SAFD_CTRL_STUFF];
    fmt1   = r.ctrl[`SAFD_CTRL_FMT];
    d      = r.esc ? (host_rx_in.data ^ `SAFD_ESC_XOR) : host_rx_in.data;
    raw    = 8'h00;
    islast = 1'b0;
    code   = {r.rbuf[2], r.rbuf[3]};
    hasv   = r.rlen > 16'h0004;
    pidx   = r.rbuf[3][2:0];
    nf     = (r.rlen > 16'(`SAFD_DEPTH)) ? `SAFD_IW'(`SAFD_DEPTH) : r.rlen[`SAFD_IW-1:0];
    if (host_tx_ready_in) begin
      n.tx.valid = 1'b0;
    end
    if (rad_tx_ready_in) begin
      n.rt.valid = 1'b0;
    end
    // Radio event start; a host delimiter in the same cycle is remembered
    if (etake && r.st == S_HUNT) begin
      n.st   = S_EVT;
      n.drop = 1'b0;
      n.olen = `SAFD_IW'(2);
      n.obuf[1] = rad_evt_in.data;
      unique case (rad_evt_in.kind)
        EV_TX_STATUS: n.obuf[0] = `SAFD_T_TXST;
        EV_RX_PKT:    n.obuf[0] = fmt1 ? `SAFD_T_RXEXP : `SAFD_T_RXPKT;
        EV_IO:        n.obuf[0] = `SAFD_T_IO;
        EV_SENSOR: begin
          n.obuf[0] = `SAFD_T_SENS;
          n.drop    = fmt1;
        end
        EV_NODE_ID: begin
          n.obuf[0] = `SAFD_T_NODE;
          n.drop    = fmt1 | ~r.ctrl[`SAFD_CTRL_COORD];
        end
        EV_REMOTE:    n.obuf[0] = `SAFD_T_RRESP;
        EV_CMD_RESP:  n.obuf[0] = `SAFD_T_RESP;
        default:      n.drop = 1'b1;
      endcase
      if (take && host_rx_in.data == `SAFD_DELIM) begin
        n.hold = 1'b1;
      end
    end else if (etake && r.st == S_EVT) begin
      if (r.olen < `SAFD_IW'(`SAFD_DEPTH)) begin
        n.obuf[r.olen[4:0]] = rad_evt_in.data;
        n.olen = r.olen + `SAFD_IW'(1);
      end
    end else if (take) begin
      if (stuff && host_rx_in.data == `SAFD_DELIM) begin
        n.st  = S_LH;
        n.esc = 1'b0;
      end else if (r.st == S_HUNT) begin
        if (host_rx_in.data == `SAFD_DELIM) begin
          n.st = S_LH;
        end
      end else if (stuff && !r.esc && host_rx_in.data == `SAFD_ESC) begin
        n.esc = 1'b1;
      end else begin
        n.esc = 1'b0;
        unique case (r.st)
          S_LH: begin
            n.rlen[15:8] = d;
            n.st = S_LL;
          end
          S_LL: begin
            n.rlen[7:0] = d;
            n.rcnt = 16'h0;
            n.rsum = 8'h00;
            n.rbuf = '0;
            n.st   = ({r.rlen[15:8], d} == 16'h0) ? S_CK : S_DAT;
          end
          S_DAT: begin
            if (r.rcnt < 16'(`SAFD_DEPTH)) begin
              n.rbuf[r.rcnt[4:0]] = d;
            end
            n.rsum = r.rsum + d;
            n.rcnt = r.rcnt + 16'h1;
            if (r.rcnt + 16'h1 == r.rlen) begin
              n.st = S_CK;
            end
          end
          default: begin
            // Bad frames are dropped silently; the error status frame is not built here
            n.st = (8'(r.rsum + d) == `SAFD_CK_GOOD && r.rlen != 16'h0) ? S_EXEC : S_HUNT;
          end
        endcase
      end
    end
    if (r.st == S_EVT && etake && rad_evt_in.last) begin
      n.st   = n.drop ? (r.hold ? S_LH : S_HUNT) : S_TX;
      n.hold = n.drop ? 1'b0 : r.hold;
      n.tidx = '0;
      n.tsum = 8'h00;
      n.tesc = 1'b0;
    end else if (r.st == S_HUNT && etake && rad_evt_in.last) begin
      n.st   = n.drop ? (n.hold ? S_LH : S_HUNT) : S_TX;
      n.hold = n.drop ? 1'b0 : n.hold;
      n.tidx = '0;
      n.tsum = 8'h00;
      n.tesc = 1'b0;
    end
    // Command execution
    if (r.st == S_EXEC) begin
      n.tidx    = '0;
      n.tsum    = 8'h00;
      n.tesc    = 1'b0;
      n.fidx    = '0;
      n.obuf[0] = `SAFD_T_RESP;
      n.obuf[1] = r.rbuf[1];
      n.obuf[2] = r.rbuf[2];
      n.obuf[3] = r.rbuf[3];
      n.obuf[4] = `SAFD_OK;
      n.olen    = `SAFD_IW'(5);
      if (r.rbuf[0] == `SAFD_T_RREQ || r.rbuf[0] == `SAFD_T_TXREQ) begin
        n.st = S_FWD;
      end else if (r.rbuf[0] == `SAFD_T_EXPL) begin
        n.st = S_FWD;
      end else if (r.rbuf[0] == `SAFD_T_CMD || r.rbuf[0] == `SAFD_T_QCMD) begin
        n.st = S_TX;
        if (code == `SAFD_C_DISC) begin
          // Replies come back later as radio events, one frame each
          n.st = S_FWD;
        end else if (code == `SAFD_C_APPLY) begin
          for (int i = 0; i < 8; i++) begin
            if (r.pend_v[i]) n.params[i] = r.pend[i];
          end
          n.pend_v = 8'h00;
        end else if (code == `SAFD_C_PERSIST) begin
          n.ctl.nvm_write = 1'b1;
        end else if (code == `SAFD_C_BIND) begin
          n.ctl.bind_write = 1'b1;
        end else if (code == `SAFD_C_RESTORE) begin
          for (int i = 0; i < 8; i++) begin
            if (3'(i) != `SAFD_P_PAN) n.params[i] = `SAFD_PARAM_RST;
          end
          n.pend_v = 8'h00;
        end else if (code == `SAFD_C_SOFT) begin
          n.rarm = 1'b1;
          n.rsd  = 28'h0;
        end else if (code == `SAFD_C_NET) begin
          n.ctl.net_restart = 1'b1;
          n.ctl.net_bcast   = hasv & r.rbuf[4][0];
        end else if (!hasv) begin
          n.obuf[5] = r.params[pidx];
          n.olen    = `SAFD_IW'(6);
        end else if (r.rbuf[0] == `SAFD_T_CMD) begin
          for (int i = 0; i < 8; i++) begin
            if (r.pend_v[i]) n.params[i] = r.pend[i];
          end
          n.pend_v       = 8'h00;
          n.params[pidx] = r.rbuf[4];
        end else begin
          n.pend[pidx]   = r.rbuf[4];
          n.pend_v[pidx] = 1'b1;
        end
      end else begin
        n.st = S_HUNT;
      end
    end
    // Radio forward of the stored frame, type byte first
    if (r.st == S_FWD && (!r.rt.valid || rad_tx_ready_in)) begin
      n.rt.valid = 1'b1;
      n.rt.data  = r.rbuf[r.fidx[4:0]];
      n.rt.last  = (r.fidx == nf - `SAFD_IW'(1));
      n.fidx     = r.fidx + `SAFD_IW'(1);
      if (n.rt.last) begin
        n.st = S_HUNT;
      end
    end
    // Frame sender
    if (r.st == S_TX && (!r.tx.valid || host_tx_ready_in)) begin
      n.tx.valid = 1'b1;
      if (r.tesc) begin
        n.tx.data = r.tpend ^ `SAFD_ESC_XOR;
        n.tesc    = 1'b0;
        islast    = r.tlast;
        n.tidx    = r.tidx + `SAFD_IW'(1);
      end else begin
        islast = (r.tidx == r.olen + `SAFD_IW'(3));
        if (r.tidx == `SAFD_IW'(0)) raw = `SAFD_DELIM;
        else if (r.tidx == `SAFD_IW'(1)) raw = 8'h00;
        else if (r.tidx == `SAFD_IW'(2)) raw = {2'h0, r.olen};
        else if (!islast) raw = r.obuf[5'(r.tidx - `SAFD_IW'(3))];
        else raw = `SAFD_CK_GOOD - r.tsum;
        if (r.tidx > `SAFD_IW'(2) && !islast) begin
          n.tsum = r.tsum + raw;
        end
        if (stuff && r.tidx != `SAFD_IW'(0) && special(raw)) begin
          n.tx.data = `SAFD_ESC;
          n.tesc    = 1'b1;
          n.tpend   = raw;
          n.tlast   = islast;
          islast    = 1'b0;
        end else begin
          n.tx.data = raw;
          n.tidx    = r.tidx + `SAFD_IW'(1);
        end
      end
      if (islast) begin
        n.st   = r.hold ? S_LH : S_HUNT;
        n.hold = 1'b0;
      end
    end
    // Delayed system reset after the soft restart reply
    if (r.rarm) begin
      n.rsd = r.rsd + 28'h1;
      if (r.rsd == 28'(RESTART_CYC - 1)) begin
        n.ctl.sys_reset   = 1'b1;
        n.ctl.net_restart = r.chg;
        n.chg  = 1'b0;
        n.rarm = 1'b0;
      end
    end
    if (n.params[`SAFD_P_PAN] != r.params[`SAFD_P_PAN] ||
        n.params[`SAFD_P_MASK] != r.params[`SAFD_P_MASK]) begin
      n.chg = 1'b1;
    end
    if (reg_wr_in && reg_addr_in == `SAFD_REG_CTRL) begin
      n.ctrl = reg_wdata_in[2:0];
    end
    if (reg_rd_in) begin
      if (reg_addr_in == `SAFD_REG_CTRL) n.rdata = {29'h0, r.ctrl};
      else if (reg_addr_in == `SAFD_REG_STAT) n.rdata = {20'h0, r.st, r.chg, r.rarm, |r.pend_v};
    end
    // Host input only while no frame is being answered
    n.rx_rdy = host_st(n.st);
    n.ev_rdy = (n.st == S_HUNT) || (n.st == S_EVT);
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      r        <= '0;
      r.st     <= S_HUNT;
      r.params <= {8{`SAFD_PARAM_RST}};
      r.ctrl   <= `SAFD_CTRL_RST;
      r.rx_rdy <= 1'b1;
      r.ev_rdy <= 1'b1;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign host_rx_ready_out = r.rx_rdy;
  assign host_tx_out       = r.tx;
  assign rad_evt_ready_out = r.ev_rdy;
  assign rad_tx_out        = r.rt;
  assign sys_ctl_out       = r.ctl;
  assign reg_rdata_out     = r.rdata;

  AST_RESP_FRAME: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && r.st == S_EXEC && r.rbuf[0] == `SAFD_T_CMD && code != `SAFD_C_DISC
    |=> r.st == S_TX && r.obuf[0] == `SAFD_T_RESP && r.obuf[1] == $past(r.rbuf[1]))
    else $error("No response frame for local command");

  AST_QUEUE_HOLD: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && r.st == S_EXEC && r.rbuf[0] == `SAFD_T_QCMD && hasv &&
    !(code inside {`SAFD_C_APPLY, `SAFD_C_RESTORE, `SAFD_C_PERSIST, `SAFD_C_BIND,
                   `SAFD_C_SOFT, `SAFD_C_NET, `SAFD_C_DISC})
    |=> $stable(r.params) && r.pend_v[$past(pidx)])
    else $error("Queued value applied too early");

  AST_FWD_TX: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && r.st == S_EXEC && r.rbuf[0] == `SAFD_T_TXREQ && !r.rt.valid
    |=> r.st == S_FWD ##1 r.rt.valid && r.rt.data == `SAFD_T_TXREQ)
    else $error("Transmit request not forwarded");

  AST_RX_FORMAT: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && etake && r.st == S_HUNT && rad_evt_in.kind == EV_RX_PKT
    |=> r.obuf[0] == ($past(fmt1) ? `SAFD_T_RXEXP : `SAFD_T_RXPKT))
    else $error("Wrong receive frame type for format option");

  AST_CK_DROP: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && take && r.st == S_CK && !(stuff && host_rx_in.data == `SAFD_DELIM) &&
    !(stuff && !r.esc && host_rx_in.data == `SAFD_ESC) && 8'(r.rsum + d) != `SAFD_CK_GOOD
    |=> r.st == S_HUNT)
    else $error("Bad checksum frame accepted");

  AST_RESYNC: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && take && !(etake && r.st == S_HUNT) && host_rx_in.data == `SAFD_DELIM &&
    (stuff || r.st == S_HUNT) |=> r.st == S_LH)
    else $error("Delimiter did not restart the parser");

  AST_ORDER: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    r.st == S_EXEC || r.st == S_FWD || r.st == S_TX || r.st == S_EVT |-> !r.rx_rdy)
    else $error("Host input accepted while a frame is open");

  AST_NET_RESTART: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && r.st == S_EXEC && r.rbuf[0] == `SAFD_T_CMD && code == `SAFD_C_NET
    |=> r.ctl.net_restart && r.ctl.net_bcast == $past(hasv & r.rbuf[4][0]) && r.st == S_TX)
    else $error("Network restart not issued with reply");

  AST_ESC_PAIR: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ce_in && r.st == S_TX && !r.tesc && (!r.tx.valid || host_tx_ready_in) && stuff &&
    r.tidx == `SAFD_IW'(3) && special(r.obuf[0]) |=> r.tx.data == `SAFD_ESC && r.tesc)
    else $error("Special byte sent without escape");
endmodule // safd_dispatcher
`default_nettype wire

/* File: sim/safd_host_model.sv */
// Host side model: sends API bytes, collects and unstuffs reply frames
`timescale 1ns/1ps
`default_nettype none
`include "safd_regs.svh"
module safd_host_model import safd_pkg::*; (
  // Clock and mode
  input  wire logic       ref_clk_in,
  input  wire logic       stuff_in,
  // Byte streams
  input  wire safd_byte_t host_tx_in,
  input  wire logic       host_rx_ready_in,
  output var  safd_byte_t host_rx_out,
  output logic            host_tx_ready_out
);
  logic [7:0] rxb[$];
  int         nfr  = 0;
  int         pos  = 0;
  int         need = 0;
  logic       esc  = 1'b0;
  logic [7:0] b;
  initial begin
    host_rx_out       = '0;
    host_tx_ready_out = 1'b0;
  end
  // Byte is held until taken; caller releases with idle
  task automatic put(input logic [7:0] d);
    host_rx_out <= '{1'b1, d};
    do @(posedge ref_clk_in); while (!host_rx_ready_in);
  endtask
  task automatic snd(input logic [7:0] d);
    if (stuff_in && d inside {8'h7e, 8'h7d, 8'h11, 8'h13}) begin
      put(`SAFD_ESC);
      put(d ^ `SAFD_ESC_XOR);
    end else put(d);
  endtask
  // Released line shows the inverse, never a stale copy
  task automatic idle();
    host_rx_out <= '{1'b0, ~host_rx_out.data};
  endtask
  // Any number of frames per command is accepted, with random stalls
  always @(posedge ref_clk_in) begin
    if (host_tx_in.valid && host_tx_ready_out) begin
      b = host_tx_in.data;
      if (b == `SAFD_DELIM) begin
        pos  = 0;
        need = 0;
      end else if (stuff_in && b == `SAFD_ESC && !esc) esc = 1'b1;
      else begin
        if (esc) b = b ^ `SAFD_ESC_XOR;
        esc = 1'b0;
        rxb.push_back(b);
        pos++;
        if (pos == 2) need = {rxb[rxb.size() - 2], b} + 3;
        if (pos == need) nfr++;
      end
    end
    host_tx_ready_out <= ($urandom % 4) != 0;
  end
endmodule // safd_host_model
`default_nettype wire

/* File: sim/serial_api_frame_dispatcher_tb.sv */
// Self-checking bench for the serial API frame dispatcher
`timescale 1ns/1ps
`default_nettype none
`include "safd_regs.svh"
module serial_api_frame_dispatcher_tb;
  import safd_pkg::*;
  logic        ref_clk_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic        stuff      = 1'b0;
  safd_byte_t  host_rx;
  safd_byte_t  host_tx;
  logic        rx_rdy;
  logic        tx_rdy;
  safd_evt_t   evt        = '0;
  logic        evt_rdy;
  safd_rad_t   rad;
  logic        rad_rdy    = 1'b0;
  safd_ctl_t   ctl;
  logic [3:0]  addr       = '0;
  logic [31:0] wdata      = '0;
  logic [31:0] rdata;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  int          n_fail     = 0;
  int          n_compared = 0;
  int          cyc        = 0;
  int          rad_end    = 0;
  int          cnt[5]     = '{default: 0};
  logic [7:0]  radq[$];
  logic [7:0]  rsp[$];
  logic [7:0]  exq[$];
  logic [7:0]  ev_typ[7]  = '{`SAFD_T_TXST, `SAFD_T_RXPKT, `SAFD_T_IO, `SAFD_T_SENS,
                             `SAFD_T_NODE, `SAFD_T_RRESP, `SAFD_T_RESP};
  logic [7:0]  fw_typ[3]  = '{`SAFD_T_TXREQ, `SAFD_T_EXPL, `SAFD_T_RREQ};

  always #4 ref_clk_in = ~ref_clk_in;

  safd_dispatcher #(.RESTART_CYC(200)) u_dut (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .ce_in(1'b1),
    .host_rx_in(host_rx), .host_rx_ready_out(rx_rdy), .host_tx_out(host_tx),
    .host_tx_ready_in(tx_rdy), .rad_evt_in(evt), .rad_evt_ready_out(evt_rdy),
    .rad_tx_out(rad), .rad_tx_ready_in(rad_rdy), .sys_ctl_out(ctl),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata));
  safd_host_model u_host (
    .ref_clk_in(ref_clk_in), .stuff_in(stuff), .host_tx_in(host_tx),
    .host_rx_ready_in(rx_rdy), .host_rx_out(host_rx), .host_tx_ready_out(tx_rdy));

  // Radio sink with random stalls, pulse counters and the hang limit
  always @(posedge ref_clk_in) begin
    cyc++;
    rad_rdy <= 1'($urandom_range(1, 0));
    if (rad.valid && rad_rdy) begin
      radq.push_back(rad.data);
      if (rad.last) rad_end = radq.size();
    end
    for (int i = 0; i < 5; i++) if (ctl[i]) cnt[i]++;
    if (cyc == 60000) begin
      n_fail++;
      final_report();
    end
  end

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata;
    @(posedge ref_clk_in);
  endtask
  task automatic send(input logic [7:0] p[$], input bit good);
    logic [7:0] s;
    s = 8'hff;
    u_host.put(`SAFD_DELIM);
    u_host.snd(8'h00);
    u_host.snd(8'(p.size()));
    foreach (p[i]) begin
      u_host.snd(p[i]);
      s -= p[i];
    end
    u_host.snd(good ? s : ~s);
    u_host.idle();
  endtask
  // Waits for one whole reply frame; the host sends nothing meanwhile
  task automatic get();
    int k;
    logic [15:0] n;
    logic [7:0] s;
    k = 0;
    rsp = {};
    while (u_host.nfr == 0 && k < 4000) begin
      @(posedge ref_clk_in);
      k++;
    end
    cmp(u_host.nfr, 1);
    if (u_host.nfr == 0) return;
    n[15:8] = u_host.rxb.pop_front();
    n[7:0] = u_host.rxb.pop_front();
    s = 8'h00;
    repeat (n) begin
      rsp.push_back(u_host.rxb.pop_front());
      s += rsp[$];
    end
    cmp(8'(s + u_host.rxb.pop_front()), `SAFD_CK_GOOD);
    u_host.nfr--;
  endtask
  task automatic at(input logic [7:0] t, input logic [7:0] c1, input logic [7:0] c2,
                    input bit hv, input logic [7:0] v);
    logic [7:0] fid;
    fid = 8'($urandom_range(255, 1));
    if (hv) send({t, fid, c1, c2, v}, 1'b1);
    else send({t, fid, c1, c2}, 1'b1);
    get();
    cmp({rsp[0], rsp[1], rsp[2], rsp[3]}, {`SAFD_T_RESP, fid, c1, c2});
    cmp(rsp[4], `SAFD_OK);
  endtask
  task automatic par(input logic [2:0] i, input logic [7:0] exp);
    at(`SAFD_T_QCMD, 8'h50, {5'h08, i}, 1'b0, 8'h00);
    cmp(rsp.size(), 6);
    cmp(rsp[5], exp);
  endtask
  task automatic spc(input logic [15:0] c, input bit hv, input logic [7:0] v, input int b,
                     input int n);
    int c0;
    c0 = cnt[b];
    at(`SAFD_T_CMD, c[15:8], c[7:0], hv, v);
    repeat (10) @(posedge ref_clk_in);
    cmp(cnt[b] - c0, n);
  endtask
  task automatic ev(input int kd, input int n, input bit drop);
    exq = {ev_typ[kd]};
    repeat (n) exq.push_back(8'($urandom));
    for (int i = 1; i <= n; i++) begin
      evt <= '{1'b1, safd_ev_t'(kd), exq[i], i == n};
      do @(posedge ref_clk_in); while (!evt_rdy);
    end
    evt <= '{1'b0, safd_ev_t'(kd), ~exq[n], 1'b0};
    if (drop) begin
      repeat (300) @(posedge ref_clk_in);
      cmp(u_host.nfr, 0);
      return;
    end
    get();
    cmp(rsp.size(), exq.size());
    foreach (exq[i]) cmp(rsp[i], exq[i]);
  endtask

  initial begin
    logic [31:0] r;
    logic [7:0] v;
    logic [7:0] w;
    logic [7:0] d[$];
    int k;
    void'($urandom(32'hff69));
    repeat (16) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge ref_clk_in);
    reg_rd(`SAFD_REG_CTRL, r);
    cmp(r, 32'h0);
    reg_rd(`SAFD_REG_STAT, r);
    cmp(r, 32'h8);
    reg_rd(4'hc, r);
    cmp(r, 32'h0);
    reg_wr(`SAFD_REG_CTRL, 32'h4);
    reg_rd(`SAFD_REG_CTRL, r);
    cmp(r, 32'h4);
    u_host.put(8'h55);
    u_host.put(8'ha3);
    v = 8'($urandom_range(255, 1));
    w = 8'($urandom_range(255, 1));
    at(`SAFD_T_QCMD, 8'h50, 8'h40, 1'b1, v);
    reg_rd(`SAFD_REG_STAT, r);
    cmp(r[0], 1'b1);
    par(3'h0, 8'h00);
    at(`SAFD_T_CMD, 8'h41, 8'h43, 1'b0, 8'h00);
    par(3'h0, v);
    at(`SAFD_T_QCMD, 8'h50, 8'h41, 1'b1, w);
    at(`SAFD_T_CMD, 8'h50, 8'h42, 1'b1, 8'h5a);
    par(3'h1, w);
    send({`SAFD_T_CMD, 8'h33, 8'h50, 8'h40, 8'h99}, 1'b0);
    par(3'h0, v);
    spc(`SAFD_C_PERSIST, 1'b0, 8'h00, 4, 1);
    spc(`SAFD_C_BIND, 1'b0, 8'h00, 3, 1);
    k = cnt[1];
    spc(`SAFD_C_SOFT, 1'b0, 8'h00, 2, 0);
    repeat (200) @(posedge ref_clk_in);
    cmp(cnt[2], 1);
    cmp(cnt[1] - k, 1);
    spc(`SAFD_C_RESTORE, 1'b0, 8'h00, 4, 0);
    par(3'h0, v);
    par(3'h1, 8'h00);
    spc(`SAFD_C_NET, 1'b1, 8'h00, 1, 1);
    spc(`SAFD_C_NET, 1'b1, 8'h01, 0, 1);
    for (int t = 0; t < 4; t++) begin
      d = {(t < 3) ? fw_typ[t % 3] : `SAFD_T_CMD, 8'($urandom_range(255, 1))};
      repeat ($urandom_range(9, 2)) d.push_back(8'($urandom));
      if (t == 3) d = {`SAFD_T_CMD, 8'h07, 8'h4e, 8'h44};
      radq = {};
      rad_end = 0;
      send(d, 1'b1);
      for (k = 0; radq.size() < d.size() && k < 2000; k++) @(posedge ref_clk_in);
      foreach (d[i]) cmp(radq[i], d[i]);
      cmp(rad_end, d.size());
      cmp(u_host.nfr, 0);
    end
    for (int j = 0; j < 8; j++) ev((j == 7) ? 6 : j, $urandom_range(12, 1), 1'b0);
    reg_wr(`SAFD_REG_CTRL, 32'h5);
    ev_typ[1] = `SAFD_T_RXEXP;
    ev(1, 6, 1'b0);
    ev(3, 4, 1'b1);
    ev(4, 4, 1'b1);
    reg_wr(`SAFD_REG_CTRL, 32'h0);
    ev(4, 4, 1'b1);
    reg_wr(`SAFD_REG_CTRL, 32'h2);
    stuff <= 1'b1;
    @(posedge ref_clk_in);
    at(`SAFD_T_CMD, 8'h50, 8'h43, 1'b1, `SAFD_DELIM);
    par(3'h3, `SAFD_DELIM);
    ev_typ[1] = `SAFD_T_RXPKT;
    ev(1, 10, 1'b0);
    final_report();
  end
endmodule // serial_api_frame_dispatcher_tb
`default_nettype wire
